// ### bec_boot_cfg.v
/*
 * bec_boot_cfg.v: reset sequencing, boot mode control, rom boot copy
 * and narrow data lane placement.
 * assumes: apb master on sys_clk_i; configuration pins and reset pin are
 * asynchronous and pass two flip-flops; external rom answers in one cycle.
 */
// Added by the designer: the address map and the APB slave port.
//
// Overview of operation
// - endian pin high selects little endian, the default ordering.
// - lane correction high: narrow data on [15:0] little, [31:16] big.
// - lane correction low: narrow data on [15:0] in either ordering.
// - little endian placement is identical with or without lane correction.
// - reset pin low holds all logic in reset at its defined state.
// - internal reset release starts cpu with latched config and boot mode.
// - three boot modes: host, emulation, external rom.
// - host boot keeps cpu stalled, other logic released for host access.
// - host sets host-to-cpu interrupt bit; stall ends, execution at 0.
// - the releasing interrupt is not recorded pending by the stalled cpu.
// - the interrupt bit releases the stall in host boot and in emulation boot, where it sets itself; not in rom boot.
// - host may write and read back every memory location during boot, except while the rom copy owns the port.
// - cpu must clear the bit; until then no further interrupts accepted.
// - rom boot copies 1K-Byte from chip select one start to address 0.
// - narrow rom reads are packed into 32-bit words; the copy always runs at the reset width, 8-bit.
// - copy is one block transfer; on completion stall ends, run from 0.
`timescale 1ns/1ps
`default_nettype none
`include "bec_defs.vh"

module bec_boot_cfg
#(
	parameter ROM_WORDS = `BEC_ROM_WORDS
)
(
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        srst_i,
	input  wire        reset_pin_n_i,
	// configuration pins
	input  wire        endian_select_pin_i,
	input  wire        lane_correction_pin_i,
	input  wire [1:0]  boot_mode_pin_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// cpu side
	input  wire        cpu_clear_int_i,
	output reg         cpu_stall_o,
	output reg  [31:0] cpu_start_addr_o,
	output reg         cpu_int_pending_o,
	output reg         internal_reset_o,
	// rom read port on chip select one
	output reg         rom_rd_o,
	output reg  [31:0] rom_addr_o,
	input  wire [31:0] rom_data_i,
	// narrow data placement
	input  wire [15:0] narrow_data_i,
	output reg  [31:0] external_data_lines_o
);

	// ==========================================================
	// pin synchronisers
	reg [4:0] sync1_reg;
	reg [4:0] sync2_reg;

	always @(posedge sys_clk_i)
	begin
		sync1_reg <= {reset_pin_n_i, endian_select_pin_i, lane_correction_pin_i,
			boot_mode_pin_i};
		sync2_reg <= sync1_reg;
	end

	wire rst_pin_n_s = sync2_reg[4];
	wire irst        = srst_i | ~rst_pin_n_s;

	// ==========================================================
	// latched configuration
	reg       byte_order_select_reg;
	reg       narrow_lane_correction_reg;
	reg [1:0] boot_mode_reg;

	// captured every reset cycle, frozen once released
	always @(posedge sys_clk_i)
	begin
		if (irst)
		begin
			byte_order_select_reg      <= sync2_reg[3];
			narrow_lane_correction_reg <= sync2_reg[2];
			boot_mode_reg              <= (sync2_reg[1:0] == 2'h3) ?
				`BEC_MODE_HOST : sync2_reg[1:0];
		end
	end

	// ==========================================================
	// state machine
	localparam ST_RESET = 3'h0;
	localparam ST_WAIT  = 3'h1;
	localparam ST_RD    = 3'h2;
	localparam ST_CAP   = 3'h3;
	localparam ST_RUN   = 3'h4;

	reg [2:0]  state_reg;
	reg [2:0]  state_next;
	reg        h2c_reg;
	reg        done_reg;
	reg [1:0]  romw_reg;
	reg [31:0] rom_base_reg;
	reg [9:0]  byte_cnt_reg;
	reg [31:0] pack_reg;
	reg [1:0]  lane_reg;

	wire       apb_acc = psel_i & penable_i & ~pready_o;
	wire       apb_wr  = apb_acc & pwrite_i;
	wire       mem_win = paddr_i[11];
	wire       host_set = apb_wr & (paddr_i == `BEC_OFS_CTRL) &
		pwdata_i[`BEC_CTRL_H2C_BIT];

	// step size per rom read
	reg [9:0] step;
	always @*
	begin
		case (romw_reg)
			`BEC_ROMW_8:  step = 10'h001;
			`BEC_ROMW_16: step = 10'h002;
			default:      step = 10'h004;
		endcase
	end

	wire [9:0] byte_cnt_nx = byte_cnt_reg + step;

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
				state_next = (boot_mode_reg == `BEC_MODE_ROM) ? ST_RD : ST_WAIT;
			ST_WAIT:
				if (h2c_reg)
					state_next = ST_RUN;
			ST_RD:
				state_next = ST_CAP;
			ST_CAP:
				if (byte_cnt_nx == 10'h000)
					state_next = ST_RUN;
				else
					state_next = ST_RD;
			ST_RUN:
				state_next = ST_RUN;
			default:
				state_next = ST_RESET;
		endcase
	end

	// ==========================================================
	// rom copy datapath
	wire       word_full = (step == 10'h004) || (lane_reg + step[1:0] == 2'h0);
	reg [31:0] pack_next;
	wire [7:0] mem_idx = byte_cnt_reg[9:2];

	// narrow reads fill lanes in the selected byte order
	always @*
	begin
		pack_next = pack_reg;
		case (romw_reg)
			`BEC_ROMW_8:
				if (byte_order_select_reg)
					pack_next[lane_reg*8 +: 8] = rom_data_i[7:0];
				else
					pack_next[(3-lane_reg)*8 +: 8] = rom_data_i[7:0];
			`BEC_ROMW_16:
				if (byte_order_select_reg)
					pack_next[lane_reg[1]*16 +: 16] = rom_data_i[15:0];
				else
					pack_next[(1-lane_reg[1])*16 +: 16] = rom_data_i[15:0];
			default:
				pack_next = rom_data_i;
		endcase
	end

	// memory port arbitration: copy engine owns it while copying
	wire        copy_we  = (state_reg == ST_CAP) & word_full;
	wire        host_we  = apb_wr & mem_win;
	wire        mem_we   = copy_we | (host_we & (state_reg != ST_RD) &
		(state_reg != ST_CAP));
	wire [7:0]  mem_addr = copy_we ? mem_idx : paddr_i[9:2];
	wire [31:0] mem_wd   = copy_we ? pack_next : pwdata_i;
	wire [31:0] mem_rd;

	bec_word_mem
	#(
		.AW (8),
		.DW (32)
	)
	u_mem
	(
		.sys_clk_i (sys_clk_i),
		.we_i      (mem_we),
		.addr_i    (mem_addr),
		.wdata_i   (mem_wd),
		.rdata_o   (mem_rd)
	);

	// ==========================================================
	// sequential state
	reg mem_rd_pend_reg;

	always @(posedge sys_clk_i)
	begin
		if (irst)
		begin
			state_reg         <= ST_RESET;
			h2c_reg           <= 1'b0;
			done_reg          <= 1'b0;
			romw_reg          <= `BEC_ROMCFG_RST;
			rom_base_reg      <= `BEC_ROM_BASE_RST;
			byte_cnt_reg      <= 10'h000;
			pack_reg          <= 32'h0000_0000;
			lane_reg          <= 2'h0;
			cpu_stall_o       <= 1'b1;
			cpu_start_addr_o  <= `BEC_BOOT_ADDR;
			cpu_int_pending_o <= 1'b0;
			internal_reset_o  <= 1'b1;
			rom_rd_o          <= 1'b0;
			rom_addr_o        <= 32'h0000_0000;
			prdata_o          <= 32'h0000_0000;
			pready_o          <= 1'b0;
			pslverr_o         <= 1'b0;
			mem_rd_pend_reg   <= 1'b0;
		end
		else
		begin
			state_reg        <= state_next;
			internal_reset_o <= 1'b0;
			cpu_stall_o      <= (state_next != ST_RUN);
			cpu_start_addr_o <= `BEC_BOOT_ADDR;
			// clear wins over a repeat set; repeat sets while pending are dropped
			if ((host_set | (state_reg == ST_WAIT & boot_mode_reg == `BEC_MODE_EMU))
				& ~h2c_reg)
			begin
				h2c_reg <= 1'b1;
				// stalled cpu never sees the boot release as an interrupt
				cpu_int_pending_o <= (state_reg == ST_RUN);
			end
			else if (cpu_clear_int_i & (state_reg == ST_RUN))
			begin
				h2c_reg           <= 1'b0;
				cpu_int_pending_o <= 1'b0;
			end
			// rom walk
			rom_rd_o <= (state_next == ST_RD);
			if (state_next == ST_RD)
				// count moves on this same edge, so the next read must lead it
				rom_addr_o <= rom_base_reg + {22'h0, (state_reg == ST_CAP) ?
					byte_cnt_nx : byte_cnt_reg};
			if (state_reg == ST_CAP)
			begin
				pack_reg     <= word_full ? 32'h0000_0000 : pack_next;
				lane_reg     <= lane_reg + step[1:0];
				byte_cnt_reg <= byte_cnt_nx;
				if (state_next == ST_RUN)
					done_reg <= 1'b1;
			end
			// apb: one wait state, answer in access cycle + 1; memory reads two wait states, answer in access cycle + 2
			pready_o        <= apb_acc & ~(mem_win & ~pwrite_i & ~mem_rd_pend_reg);
			mem_rd_pend_reg <= apb_acc & mem_win & ~pwrite_i & ~mem_rd_pend_reg;
			pslverr_o       <= 1'b0;
			if (apb_acc & mem_win & ~pwrite_i & mem_rd_pend_reg)
				prdata_o <= mem_rd;
			// memory window is not a register decode: no error on its wait cycle
			else if (apb_acc & ~pwrite_i & ~mem_win)
			begin
				case (paddr_i)
					`BEC_OFS_CTRL:   prdata_o <= {31'h0, h2c_reg};
					`BEC_OFS_STATUS: prdata_o <= {26'h0, done_reg, boot_mode_reg,
						narrow_lane_correction_reg, byte_order_select_reg, cpu_stall_o};
					`BEC_OFS_ROMCFG: prdata_o <= {30'h0, romw_reg};
					`BEC_OFS_ROMSRC: prdata_o <= rom_base_reg;
					default:
					begin
						prdata_o  <= 32'h0000_0000;
						pslverr_o <= 1'b1;
					end
				endcase
			end
			if (apb_wr & (state_reg == ST_WAIT | state_reg == ST_RUN))
			begin
				if (paddr_i == `BEC_OFS_ROMCFG)
					romw_reg <= pwdata_i[1:0];
				if (paddr_i == `BEC_OFS_ROMSRC)
					rom_base_reg <= pwdata_i;
			end
			if (apb_wr & ~mem_win & (paddr_i != `BEC_OFS_CTRL) &
				(paddr_i != `BEC_OFS_ROMCFG) & (paddr_i != `BEC_OFS_ROMSRC))
				pslverr_o <= 1'b1;
		end
	end

	// ==========================================================
	// narrow lane placement
	always @(posedge sys_clk_i)
	begin
		if (irst)
			external_data_lines_o <= 32'h0000_0000;
		else if (byte_order_select_reg | ~narrow_lane_correction_reg)
			external_data_lines_o <= {16'h0000, narrow_data_i};
		else
			external_data_lines_o <= {narrow_data_i, 16'h0000};
	end

endmodule

`default_nettype wire

// ### bec_defs.vh
/*
 * bec_defs.vh: constants for the boot and endian configuration block.
 * assumes: included by bare name from the design files; definitions only.
 */
`ifndef BEC_DEFS_VH
`define BEC_DEFS_VH

// ==========================================================
// register byte offsets
`define BEC_OFS_CTRL      12'h000
`define BEC_OFS_STATUS    12'h004
`define BEC_OFS_ROMCFG    12'h008
`define BEC_OFS_ROMSRC    12'h00c

// ==========================================================
// control register fields
`define BEC_CTRL_H2C_BIT  0

// ==========================================================
// status register fields
`define BEC_ST_STALL_BIT  0
`define BEC_ST_LE_BIT     1
`define BEC_ST_LC_BIT     2
`define BEC_ST_MODE_LSB   3
`define BEC_ST_DONE_BIT   5

// ==========================================================
// boot mode codes
`define BEC_MODE_HOST     2'h0
`define BEC_MODE_EMU      2'h1
`define BEC_MODE_ROM      2'h2

// ==========================================================
// rom width codes
`define BEC_ROMW_8        2'h0
`define BEC_ROMW_16       2'h1
`define BEC_ROMW_32       2'h2

// ==========================================================
// reset values and counts
`define BEC_ROMCFG_RST    2'h0
`define BEC_ROM_BYTES     1024
`define BEC_ROM_WORDS     256
`define BEC_BOOT_ADDR     32'h0000_0000
`define BEC_ROM_BASE_RST  32'h9000_0000

`endif

// ### bec_props.sv
/*
 * bec_props.sv: checker for the boot and endian block.
 * assumes: bound to bec_boot_cfg; one clock, srst_i high resets.
 */
`timescale 1ns/1ps
`default_nettype none
module bec_props (
	// clock and reset
	input wire        sys_clk_i,
	input wire        srst_i,
	input wire        reset_pin_n_i,
	// apb
	input wire        psel_i,
	input wire        penable_i,
	input wire        pready_o,
	input wire        pslverr_o,
	// cpu and rom
	input wire        cpu_stall_o,
	input wire [31:0] cpu_start_addr_o,
	input wire        cpu_int_pending_o,
	input wire        internal_reset_o,
	input wire        rom_rd_o,
	// lanes
	input wire [15:0] narrow_data_i,
	input wire [31:0] external_data_lines_o
);
	// ==========================================================
	// properties
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_req;
		psel_i && !penable_i ##1 psel_i && penable_i;
	endsequence
	sequence s_run;
		!internal_reset_o ##1 !internal_reset_o;
	endsequence
	property p_rst_hold;
		internal_reset_o |-> cpu_stall_o && !cpu_int_pending_o;
	endproperty
	property p_pin;
		$fell(reset_pin_n_i) |-> ##[1:4] internal_reset_o;
	endproperty
	property p_start;
		cpu_start_addr_o == 32'h0;
	endproperty
	property p_no_pend;
		cpu_stall_o |-> !cpu_int_pending_o;
	endproperty
	property p_lane;
		s_run |-> external_data_lines_o == {16'h0, $past(narrow_data_i)} ||
			external_data_lines_o == {$past(narrow_data_i), 16'h0};
	endproperty
	property p_stall_rise;
		$rose(cpu_stall_o) |-> internal_reset_o;
	endproperty
	property p_ready;
		s_req |-> ##[0:3] pready_o;
	endproperty
	property p_err;
		pslverr_o |-> pready_o;
	endproperty
	property p_rom_stall;
		rom_rd_o |-> cpu_stall_o;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset state lost");
	a_pin: assert property (p_pin) else $error("pin reset not taken");
	a_start: assert property (p_start) else $error("start address not zero");
	a_no_pend: assert property (p_no_pend) else $error("pending while stalled");
	a_lane: assert property (p_lane) else $error("narrow data off lane");
	a_stall_rise: assert property (p_stall_rise) else $error("stall outside reset");
	a_ready: assert property (p_ready) else $error("no apb answer");
	a_err: assert property (p_err) else $error("error without ready");
	a_rom_stall: assert property (p_rom_stall) else $error("rom read while running");
endmodule
bind bec_boot_cfg bec_props u_props (.sys_clk_i, .srst_i, .reset_pin_n_i, .psel_i,
	.penable_i, .pready_o, .pslverr_o, .cpu_stall_o, .cpu_start_addr_o,
	.cpu_int_pending_o, .internal_reset_o, .rom_rd_o, .narrow_data_i, .external_data_lines_o);
`default_nettype wire

// ### bec_rom_model.sv
/*
 * bec_rom_model.sv: behavioural boot rom on chip select one.
 * assumes: one-cycle rom, data read the cycle after a read strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module bec_rom_model (
	// clock
	input  wire         sys_clk_i,
	// read port
	input  wire         rom_rd_i,
	input  wire  [31:0] rom_addr_i,
	output logic [31:0] rom_data_o
);
	// ==========================================================
	// data
	initial rom_data_o = 32'h0;
	// byte lanes above the width carry junk; idle data toggles, never stale
	always @(posedge sys_clk_i)
		if (rom_rd_i)
			rom_data_o <= {rom_addr_i[31:8], rom_addr_i[7:0] ^ 8'h5a};
		else
			rom_data_o <= ~rom_data_o;
endmodule
`default_nettype wire

// ### bec_word_mem.v
/*
 * bec_word_mem.v: small single-port word memory holding the boot image.
 * assumes: one clock; read data registered, one cycle latency.
 */
`timescale 1ns/1ps
`default_nettype none

module bec_word_mem
#(
	parameter AW = 8,
	parameter DW = 32
)
(
	// clock
	input  wire          sys_clk_i,
	// port
	input  wire          we_i,
	input  wire [AW-1:0] addr_i,
	input  wire [DW-1:0] wdata_i,
	output reg  [DW-1:0] rdata_o
);

	// ==========================================================
	// storage
	reg [DW-1:0] mem_reg [0:(1<<AW)-1];

	always @(posedge sys_clk_i)
	begin
		if (we_i)
			mem_reg[addr_i] <= wdata_i;
		rdata_o <= mem_reg[addr_i];
	end

endmodule

`default_nettype wire

// ### tb.sv
/*
 * tb.sv: self-checking bench for the boot and endian block.
 * assumes: design, rom model and checker compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ==========================================================
	// signals, named as the ports they feed
	logic        sys_clk_i = 1'h0;
	logic        srst_i = 1'h1;
	logic        reset_pin_n_i = 1'h1;
	logic        endian_select_pin_i = 1'h1;
	logic        lane_correction_pin_i = 1'h1;
	logic [1:0]  boot_mode_pin_i = 2'h0;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [11:0] paddr_i = 12'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic        cpu_clear_int_i = 1'h0;
	logic [15:0] narrow_data_i = 16'hc3a5;
	logic [31:0] prdata_o, cpu_start_addr_o, rom_addr_o, rom_data_i, external_data_lines_o;
	logic        pready_o, pslverr_o, cpu_stall_o, cpu_int_pending_o, internal_reset_o, rom_rd_o;
	logic [31:0] rd;
	logic        err;
	logic [7:0]  idx;
	int          n_fail = 0;
	int          n_tests = 0;
	always #25 sys_clk_i = ~sys_clk_i;
	bec_boot_cfg u_dut (.sys_clk_i, .srst_i, .reset_pin_n_i, .endian_select_pin_i,
		.lane_correction_pin_i, .boot_mode_pin_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cpu_clear_int_i, .cpu_stall_o,
		.cpu_start_addr_o, .cpu_int_pending_o, .internal_reset_o, .rom_rd_o, .rom_addr_o,
		.rom_data_i, .narrow_data_i, .external_data_lines_o);
	bec_rom_model u_rom (.sys_clk_i, .rom_rd_i(rom_rd_o), .rom_addr_i(rom_addr_o),
		.rom_data_o(rom_data_i));
	// ==========================================================
	// tasks
	task automatic chk(input [31:0] got, input [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input w, input [11:0] a, input [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'h1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'h1;
		@(posedge sys_clk_i);
		while (pready_o !== 1'h1)
			@(posedge sys_clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'h0;
		penable_i <= 1'h0;
	endtask
	// pins are held through the whole reset so they latch cleanly
	task automatic boot(input [1:0] m, input le, input lc, input pin);
		@(posedge sys_clk_i);
		boot_mode_pin_i <= m;
		endian_select_pin_i <= le;
		lane_correction_pin_i <= lc;
		if (pin)
			reset_pin_n_i <= 1'h0;
		else
			srst_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		reset_pin_n_i <= 1'h1;
		srst_i <= 1'h0;
		repeat (5) @(posedge sys_clk_i);
		chk(internal_reset_o, 32'h0);
		chk(external_data_lines_o, (le || !lc) ? {16'h0, narrow_data_i}
			: {narrow_data_i, 16'h0});
	endtask
	task automatic wstall();
		for (int i = 0; i < 6000 && cpu_stall_o !== 1'h0; i++)
			@(posedge sys_clk_i);
	endtask
	function automatic [31:0] romw(input [7:0] i);
		romw = (32'h03020100 + {4{i[5:0], 2'h0}}) ^ 32'h5a5a5a5a;
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// sequence
	initial
	begin
		boot(2'h0, 1'h1, 1'h1, 1'h1);
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h7);
		apb(1'h0, 12'h010, 32'h0);
		chk(err, 32'h1);
		apb(1'h1, 12'h804, 32'h1234abcd);
		apb(1'h0, 12'h804, 32'h0);
		chk(rd, 32'h1234abcd);
		chk(cpu_stall_o, 32'h1);
		for (int n = 0; n < 3; n++)
		begin
			if (n == 2)
				cpu_clear_int_i <= 1'h1;
			@(posedge sys_clk_i);
			cpu_clear_int_i <= 1'h0;
			apb(1'h1, 12'h000, 32'h1);
			repeat (3) @(posedge sys_clk_i);
			// released but not pending, repeat set dropped, set after clear pends
			chk({cpu_stall_o, cpu_int_pending_o}, (n == 2) ? 32'h1 : 32'h0);
		end
		chk(cpu_start_addr_o, 32'h0);
		apb(1'h1, 12'h008, 32'h1);
		apb(1'h0, 12'h008, 32'h0);
		chk(rd, 32'h1);
		boot(2'h1, 1'h0, 1'h1, 1'h1);
		wstall();
		chk(cpu_stall_o, 32'h0);
		chk(cpu_start_addr_o, 32'h0);
		boot(2'h2, 1'h1, 1'h0, 1'h0);
		apb(1'h1, 12'h000, 32'h1);
		repeat (3) @(posedge sys_clk_i);
		chk(cpu_stall_o, 32'h1);
		wstall();
		// words 0, 127 and 254
		for (idx = 8'h0; idx != 8'h7d; idx = idx + 8'h7f)
		begin
			apb(1'h0, {2'h2, idx, 2'h0}, 32'h0);
			chk(rd, romw(idx));
		end
		apb(1'h0, 12'h004, 32'h0);
		chk(rd, 32'h32);
		boot(2'h0, 1'h0, 1'h0, 1'h0);
		end_of_test();
	end
	initial
	begin
		repeat (40000) @(posedge sys_clk_i);
		n_fail++;
		end_of_test();
	end
endmodule
`default_nettype wire
